// File: verilog/nic_defines.svh
`ifndef NIC_DEFINES_SVH
`define NIC_DEFINES_SVH

// ****************************************************************
// Sizes and register map
// ****************************************************************
`define NIC_NUM_VEC 14
`define NIC_EXT_FIRST 2
`define NIC_EXT_GROUPS 4
`define NIC_EXT_PINS 2
`define NIC_ADDR_CC 8'h00
`define NIC_ADDR_EN 8'h04
`define NIC_ADDR_PEND 8'h08
`define NIC_ADDR_STAT 8'h0C
`define NIC_ISPR_PAGE 4'h1
`define NIC_RESP_OKAY 2'b00
`define NIC_RESP_SLVERR 2'b10

// ****************************************************************
// Reset values, codes and vectors
// ****************************************************************
`define NIC_CC_RESET 8'hEA
`define NIC_CC_ONES 8'hC0
`define NIC_ISPR_RESET 8'hFF
`define NIC_ISPR3_RO 8'hF0
`define NIC_CC_HI 5
`define NIC_CC_LO 3
`define NIC_CODE_L0 2'b10
`define NIC_CODE_L1 2'b01
`define NIC_CODE_L2 2'b00
`define NIC_CODE_L3 2'b11
`define NIC_VEC_RESET 16'hFFFE
`define NIC_VEC_TRAP 16'hFFFC
`define NIC_VEC_BASE 16'hFFFA
`define NIC_STACK_LAST 2'h3
`define NIC_WAKE_MASK 14'h013F

`endif

// File: verilog/nic_pkg.sv
`include "nic_defines.svh"

package nic_pkg;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STACK = 2'b01,
    ST_VECT = 2'b10
  } nic_state_e;

  // Turns a two-bit priority code into a numeric level, 0 lowest.
  function automatic logic [1:0] nic_level(input logic [1:0] code);
    unique case (code)
      `NIC_CODE_L0: nic_level = 2'h0;
      `NIC_CODE_L1: nic_level = 2'h1;
      `NIC_CODE_L2: nic_level = 2'h2;
      `NIC_CODE_L3: nic_level = 2'h3;
    endcase
  endfunction : nic_level

endpackage : nic_pkg

// File: verilog/nic_arb_if.sv
`timescale 1ns/10ps
`include "nic_defines.svh"

// Carries pending requests and priorities to the arbiter and back.
interface nic_arb_if;
  logic [`NIC_NUM_VEC-1:0] pending;
  logic [2*`NIC_NUM_VEC-1:0] prio_code;
  logic [1:0] cur_level;
  logic halt_only;
  logic win_valid;
  logic [3:0] win_idx;
  logic [1:0] win_code;
  modport regs (output prio_code);
  modport arb (input pending, prio_code, cur_level, halt_only,
    output win_valid, win_idx, win_code);
  modport top (output pending, cur_level, halt_only,
    input prio_code, win_valid, win_idx, win_code);
endinterface : nic_arb_if

// File: verilog/nic_arbiter.sv
`timescale 1ns/10ps
`include "nic_defines.svh"

module nic_arbiter #(
  parameter logic [`NIC_NUM_VEC-1:0] WAKE_MASK = `NIC_WAKE_MASK
) (
  nic_arb_if.arb arb
);

  // ****************************************************************
  // Two-step decision: software level first, then vector rank
  // ****************************************************************
  // Walking down from the last vector with >= lets the lower vector
  // number win every tie, so rank falls as the number rises.
  always_comb begin
    logic [1:0] lvl;
    logic [1:0] best;
    best = 2'h0;
    lvl = 2'h0;
    arb.win_valid = 1'b0;
    arb.win_idx = 4'h0;
    arb.win_code = `NIC_CODE_L3;
    for (int i = `NIC_NUM_VEC - 1; i >= 0; i--) begin
      lvl = nic_pkg::nic_level(arb.prio_code[2*i+:2]);
      if (arb.pending[i] && lvl > arb.cur_level &&
          (!arb.halt_only || WAKE_MASK[i]) &&
          (!arb.win_valid || lvl >= best)) begin
        arb.win_valid = 1'b1;
        arb.win_idx = 4'(i);
        arb.win_code = arb.prio_code[2*i+:2];
        best = lvl;
      end
    end
  end

endmodule : nic_arbiter

// File: verilog/nic_prio_regs.sv
`timescale 1ns/10ps
`include "nic_defines.svh"

module nic_prio_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data,
  nic_arb_if.regs arb
);

  logic [7:0] isp [4];

  // ****************************************************************
  // Per-vector priority storage
  // ****************************************************************
  // A pair written with the level-0 code keeps its old value, so no
  // vector can ever sit at the main-program level.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int r = 0; r < 4; r++) begin
        isp[r] <= `NIC_ISPR_RESET;
      end
    end else if (wr_en) begin
      for (int p = 0; p < 4; p++) begin
        if (wr_data[2*p+:2] != `NIC_CODE_L0 &&
            !(wr_idx == 2'h3 && p >= 2)) begin
          isp[wr_idx][2*p+:2] <= wr_data[2*p+:2];
        end
      end
    end
  end

  // Reads show the fixed upper nibble of the last register as ones.
  assign rd_data = isp[rd_idx] |
    ((rd_idx == 2'h3) ? `NIC_ISPR3_RO : 8'h00);

  // Flatten the pairs for the arbiter, vector 0 in the low bits.
  for (genvar v = 0; v < `NIC_NUM_VEC; v++) begin : g_code
    assign arb.prio_code[2*v+:2] = isp[v/4][2*(v%4)+:2];
  end

  chk_keep_level0: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_en && wr_idx == 2'h0 && wr_data[1:0] == `NIC_CODE_L0
    |=> isp[0][1:0] == $past(isp[0][1:0]))
    else $error("Level-0 write changed a stored priority pair.");

endmodule : nic_prio_regs

// File: verilog/nic_top.sv
`timescale 1ns/10ps
`include "nic_defines.svh"


module nic_top #(
  parameter int NV = `NIC_NUM_VEC,
  parameter int NG = `NIC_EXT_GROUPS,
  parameter int NP = `NIC_EXT_PINS,
  parameter logic [`NIC_NUM_VEC-1:0] WAKE_MASK = `NIC_WAKE_MASK
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NV-1:0] periph_flag,
  input wire logic [NG*NP-1:0] ext_pin,
  input wire logic instr_boundary,
  input wire logic trap_instr,
  input wire logic return_from_isr_instr,
  input wire logic [7:0] restore_cc_data,
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic wait_for_irq_instr,
  input wire logic halt_instr,
  output logic stack_push,
  output logic [1:0] stack_sel,
  output logic [7:0] stack_cc,
  output logic vec_load,
  output logic [15:0] vec_addr,
  output logic [7:0] condition_code_register,
  output logic low_power_wait,
  output logic low_power_halt,
  output logic cpu_wake
);

  nic_arb_if arb ();
  nic_pkg::nic_state_e st;
  logic [1:0] cnt;
  logic [7:0] cc;
  logic [NV-1:0] en;
  logic [NG-1:0] ext_latch;
  logic [NG*NP-1:0] pin_s1;
  logic [NG*NP-1:0] pin_s2;
  logic [NG-1:0] grp;
  logic [NG-1:0] grp_d;
  logic [NG-1:0] rise;
  logic [NV-1:0] raw;
  logic trap_pend;
  logic take;
  logic [15:0] svc_addr;
  logic [1:0] svc_code;
  logic svc_mask;
  logic [3:0] last_vec;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic cc_wr;
  logic en_wr;
  logic pend_wr;
  logic isp_wr;
  logic [7:0] isp_rd;
  logic [NG-1:0] ext_clr;

  // ****************************************************************
  // Address decoding shared by the read and write paths
  // ****************************************************************
  function automatic logic nic_is_ispr(input logic [7:0] a);
    nic_is_ispr = a[7:4] == `NIC_ISPR_PAGE && a[1:0] == 2'h0;
  endfunction : nic_is_ispr

  function automatic logic nic_mapped(input logic [7:0] a);
    nic_mapped = nic_is_ispr(a) || a == `NIC_ADDR_CC ||
      a == `NIC_ADDR_EN || a == `NIC_ADDR_PEND || a == `NIC_ADDR_STAT;
  endfunction : nic_mapped

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data are held separately, so either may come first;
  // the response goes out one cycle after the later of the two.
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NIC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= nic_mapped(aw_addr) ? `NIC_RESP_OKAY
                                          : `NIC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register strobes; only the low byte lane matters for 8-bit ones.
  assign cc_wr = wr_go && aw_addr == `NIC_ADDR_CC && w_strb[0];
  assign en_wr = wr_go && aw_addr == `NIC_ADDR_EN;
  assign pend_wr = wr_go && aw_addr == `NIC_ADDR_PEND && w_strb[0];
  assign isp_wr = wr_go && nic_is_ispr(aw_addr) && w_strb[0];

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NIC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= nic_mapped(s_axi_araddr) ? `NIC_RESP_OKAY
                                               : `NIC_RESP_SLVERR;
      if (nic_is_ispr(s_axi_araddr)) begin
        s_axi_rdata <= {24'h000000, isp_rd};
      end else begin
        unique case (s_axi_araddr)
          `NIC_ADDR_CC: s_axi_rdata <= {24'h000000, cc};
          `NIC_ADDR_EN: s_axi_rdata <= {18'h0, en};
          `NIC_ADDR_PEND: s_axi_rdata <= {18'h0, arb.pending};
          `NIC_ADDR_STAT: s_axi_rdata <= {22'h0, trap_pend,
            last_vec, st, low_power_halt, low_power_wait, 1'b0};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Priority storage and arbitration
  // ****************************************************************
  nic_prio_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(isp_wr),
    .wr_idx(aw_addr[3:2]),
    .wr_data(w_data[7:0]),
    .rd_idx(s_axi_araddr[3:2]),
    .rd_data(isp_rd),
    .arb(arb)
  );

  nic_arbiter #(.WAKE_MASK(WAKE_MASK)) u_arb (
    .arb(arb)
  );

  // ****************************************************************
  // Request sources
  // ****************************************************************
  // Pins are asynchronous, so they pass two flops before the OR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      grp_d <= '0;
    end else begin
      pin_s1 <= ext_pin;
      pin_s2 <= pin_s1;
      grp_d <= grp;
    end
  end

  for (genvar g = 0; g < NG; g++) begin : g_ext
    assign grp[g] = |pin_s2[g*NP+:NP];
    assign rise[g] = grp[g] && !grp_d[g];
    assign ext_clr[g] = (take && !trap_pend &&
      arb.win_idx == 4'(g + `NIC_EXT_FIRST)) ||
      (pend_wr && w_data[g + `NIC_EXT_FIRST]);
  end

  // A new edge in the clearing cycle survives, so no edge is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_latch <= '0;
    end else begin
      ext_latch <= rise | (ext_latch & ~ext_clr);
    end
  end

  // Peripheral requests follow their flags, so a cleared flag drops a
  // request still waiting for service.
  for (genvar v = 0; v < NV; v++) begin : g_src
    if (v >= `NIC_EXT_FIRST && v < `NIC_EXT_FIRST + NG) begin : g_e
      assign raw[v] = ext_latch[v - `NIC_EXT_FIRST];
    end else begin : g_p
      assign raw[v] = periph_flag[v];
    end
  end

  assign arb.pending = raw & en;
  assign arb.cur_level = nic_pkg::nic_level({cc[`NIC_CC_HI],
    cc[`NIC_CC_LO]});
  assign arb.halt_only = low_power_halt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= '0;
    end else if (en_wr) begin
      if (w_strb[0]) en[7:0] <= w_data[7:0];
      if (w_strb[1]) en[NV-1:8] <= w_data[NV-1:8];
    end
  end

  // The trap flag is set by the instruction and dropped on service.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trap_pend <= 1'b0;
    end else begin
      trap_pend <= trap_instr || (trap_pend && !take);
    end
  end

  // ****************************************************************
  // Entry sequencer
  // ****************************************************************
  // A stopped core has no instruction to finish, so a wake takes the
  // request at once; otherwise it waits for the boundary.
  assign take = st == nic_pkg::ST_IDLE && (trap_pend || arb.win_valid)
    && (instr_boundary || low_power_wait || low_power_halt);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= nic_pkg::ST_VECT;
      cnt <= 2'h0;
    end else begin
      unique case (st)
        nic_pkg::ST_IDLE: begin
          cnt <= 2'h0;
          if (take) st <= nic_pkg::ST_STACK;
        end
        nic_pkg::ST_STACK: begin
          cnt <= cnt + 2'h1;
          if (cnt == `NIC_STACK_LAST) st <= nic_pkg::ST_VECT;
        end
        nic_pkg::ST_VECT: st <= nic_pkg::ST_IDLE;
        default: st <= nic_pkg::ST_IDLE;
      endcase
    end
  end

  // Capture what is serviced; trap outranks every maskable vector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_addr <= `NIC_VEC_RESET;
      svc_code <= `NIC_CODE_L3;
      svc_mask <= 1'b0;
      last_vec <= 4'hF;
    end else if (take && trap_pend) begin
      svc_addr <= `NIC_VEC_TRAP;
      svc_code <= `NIC_CODE_L3;
      svc_mask <= 1'b0;
      last_vec <= 4'hE;
    end else if (take) begin
      svc_addr <= `NIC_VEC_BASE - {11'h000, arb.win_idx, 1'b0};
      svc_code <= arb.win_code;
      svc_mask <= 1'b1;
      last_vec <= arb.win_idx;
    end
  end

  // Stack words go out as program counter, index, accumulator, codes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_sel <= 2'h0;
      vec_addr <= `NIC_VEC_RESET;
    end else begin
      stack_sel <= (st == nic_pkg::ST_STACK) ? cnt + 2'h1 : 2'h0;
      vec_addr <= svc_addr;
    end
  end

  assign stack_push = st == nic_pkg::ST_STACK;
  assign vec_load = st == nic_pkg::ST_VECT;
  assign stack_cc = cc;
  assign condition_code_register = cc;
  assign cpu_wake = take && (low_power_wait || low_power_halt);

  // ****************************************************************
  // Condition codes and low-power modes
  // ****************************************************************
  // Entry changes the level only at vector load, after the old codes
  // have been stacked; bits 7 and 6 always read as ones.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc <= `NIC_CC_RESET;
    end else if (st == nic_pkg::ST_VECT) begin
      cc[`NIC_CC_HI] <= svc_code[1];
      cc[`NIC_CC_LO] <= svc_code[0];
    end else if (return_from_isr_instr) begin
      cc <= restore_cc_data | `NIC_CC_ONES;
    end else if (disable_irq_instr) begin
      cc[`NIC_CC_HI] <= 1'b1;
      cc[`NIC_CC_LO] <= 1'b1;
    end else if (enable_irq_instr || wait_for_irq_instr || halt_instr)
    begin
      cc[`NIC_CC_HI] <= 1'b1;
      cc[`NIC_CC_LO] <= 1'b0;
    end else if (cc_wr) begin
      cc <= w_data[7:0] | `NIC_CC_ONES;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_power_wait <= 1'b0;
      low_power_halt <= 1'b0;
    end else if (take) begin
      low_power_wait <= 1'b0;
      low_power_halt <= 1'b0;
    end else begin
      if (wait_for_irq_instr) low_power_wait <= 1'b1;
      if (halt_instr) low_power_halt <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_boot_vector: assert property (@(posedge aclk) disable iff
    (!aresetn) $rose(aresetn) |-> vec_load && !stack_push)
    else $error("Reset entry did not go straight to the vector.");

  chk_stack_burst: assert property (@(posedge aclk) disable iff
    (!aresetn) $rose(stack_push) |-> stack_push [*4] ##1 vec_load)
    else $error("Stacking was not four words then vector load.");

  chk_level_load: assert property (@(posedge aclk) disable iff
    (!aresetn) vec_load && svc_mask |=> {cc[`NIC_CC_HI],
    cc[`NIC_CC_LO]} == $past(svc_code))
    else $error("Entry level differs from the vector priority.");

  chk_nmi_level: assert property (@(posedge aclk) disable iff
    (!aresetn) vec_load && !svc_mask |=> cc[`NIC_CC_HI] &&
    cc[`NIC_CC_LO])
    else $error("Non-maskable entry did not set level 3.");

  chk_after_boundary: assert property (@(posedge aclk) disable iff
    (!aresetn) $rose(stack_push) |-> $past(instr_boundary) ||
    $past(low_power_wait) || $past(low_power_halt))
    else $error("Entry began inside an instruction.");

  chk_mask_level: assert property (@(posedge aclk) disable iff
    (!aresetn) take && !trap_pend |-> nic_pkg::nic_level(arb.win_code)
    > arb.cur_level && en[arb.win_idx])
    else $error("Maskable request taken without enable or level.");

  chk_halt_first: assert property (@(posedge aclk) disable iff
    (!aresetn) take && low_power_halt && !trap_pend |->
    WAKE_MASK[arb.win_idx])
    else $error("Halt left through a non-wake-capable vector.");

  chk_trap_vector: assert property (@(posedge aclk) disable iff
    (!aresetn) take && trap_pend |-> ##5 vec_load &&
    vec_addr == `NIC_VEC_TRAP)
    else $error("Trap did not reach its vector in time.");

endmodule : nic_top

// File: verif/nic_core_model.sv
`timescale 1ns/10ps
// Core stand-in: counts stacked words and records each fetched vector.
module nic_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stack_push,
  input wire logic vec_load,
  input wire logic [15:0] vec_addr,
  input wire logic [1:0] stack_sel,
  input wire logic [7:0] stack_cc,
  output logic instr_boundary,
  output logic [7:0] pushed,
  output logic [7:0] loads,
  output logic [15:0] last_vec,
  output logic [7:0] sel_bad,
  output logic [7:0] saved_cc
);
  logic [7:0] cnt;
  // Two-cycle instructions: a request must wait for the boundary.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_boundary <= 1'b0;
    end else begin
      instr_boundary <= !instr_boundary;
    end
  end
  // Pushes since the last fetch are handed over when the fetch happens.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      loads <= 8'h00;
      sel_bad <= 8'h00;
    end else if (vec_load) begin
      pushed <= cnt;
      cnt <= 8'h00;
      loads <= loads + 8'h01;
      last_vec <= vec_addr;
    end else if (stack_push) begin
      cnt <= cnt + 8'h01;
      // Word order is judged by the model's own count, not by the index.
      if (stack_sel !== cnt[1:0]) sel_bad <= sel_bad + 8'h01;
      if (cnt[1:0] == 2'h3) saved_cc <= stack_cc;
    end
  end
endmodule : nic_core_model

// File: verif/nic_top_tb_top.sv
`timescale 1ns/10ps
module nic_top_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, instr_boundary;
  logic trap_instr, return_from_isr_instr, enable_irq_instr, cpu_wake;
  logic disable_irq_instr, wait_for_irq_instr, halt_instr, stack_push;
  logic vec_load, low_power_wait, low_power_halt;
  logic [7:0] s_axi_awaddr, s_axi_araddr, restore_cc_data, stack_cc;
  logic [7:0] condition_code_register, ext_pin, pushed, loads;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, stack_sel;
  logic [13:0] periph_flag;
  logic [15:0] vec_addr, last_vec;
  logic [7:0] sel_bad, saved_cc;
  int num_errors, n_checks;

  nic_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_flag, .ext_pin,
    .instr_boundary, .trap_instr, .return_from_isr_instr,
    .restore_cc_data, .enable_irq_instr, .disable_irq_instr,
    .wait_for_irq_instr, .halt_instr, .stack_push, .stack_sel,
    .stack_cc, .vec_load, .vec_addr, .condition_code_register,
    .low_power_wait, .low_power_halt, .cpu_wake);
  nic_core_model core (.aclk, .aresetn, .stack_push, .vec_load,
    .vec_addr, .stack_sel, .stack_cc, .instr_boundary, .pushed, .loads,
    .last_vec, .sel_bad, .saved_cc);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  // Both channels are released only at the edge where they were taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ar, wr, b;
    logic [1:0] rs;
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(negedge aclk);
      ar = s_axi_awready & s_axi_awvalid;
      wr = s_axi_wready & s_axi_wvalid;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      t++;
      @(posedge aclk);
      if (ar) s_axi_awvalid <= 1'b0;
      if (wr) s_axi_wvalid <= 1'b0;
    end while (!b && t < 50);
    // Ready stays up between calls; a timeout shows as a missing answer.
    chk("write_resp", 32'h4, {29'h0, b, rs});
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic ar, r;
    logic [1:0] rr;
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(negedge aclk);
      ar = s_axi_arready & s_axi_arvalid;
      r = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      t++;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r && t < 50);
    chk("read_resp", 32'h4, {29'h0, r, rr});
  endtask : axr

  // Waits for one vector fetch, then checks address, stacking and level.
  task automatic entry(input logic [15:0] v, input logic [1:0] c,
    input logic [7:0] sc);
    logic [7:0] n;
    int t;
    n = loads;
    t = 0;
    do begin
      @(negedge aclk);
      t++;
    end while (loads === n && t < 60);
    chk("fetch", {24'h0, n + 8'h01}, {24'h0, loads});
    chk("vector", {16'h0000, v}, {16'h0000, last_vec});
    chk("stacked", 32'h4, {24'h0, pushed});
    chk("stack_order", 32'h0, {24'h0, sel_bad});
    chk("stack_cc", {24'h0, sc}, {24'h0, saved_cc});
    chk("level", {30'h0, c}, {30'h0, condition_code_register[5],
      condition_code_register[3]});
    @(posedge aclk);
  endtask : entry

  task automatic t_regs;
    axr(8'h00);
    chk("cc", 32'hEA, rd);
    axr(8'h1C);
    chk("ispr3", 32'hFF, rd);
    chk("boot", 32'hFFFE, {16'h0, last_vec});
    axw(8'h10, 32'h64);
    axw(8'h10, 32'h66);
    axr(8'h10);
    chk("ispr0", 32'h74, rd);
    axw(8'h1C, 32'h00);
    axr(8'h1C);
    chk("ispr3", 32'hF0, rd);
    $display("registers done");
  endtask : t_regs

  task automatic t_flow;
    axw(8'h04, 32'h3);
    periph_flag <= 14'h0003;
    repeat (10) @(posedge aclk);
    chk("masked", 32'h1, {24'h0, loads});
    enable_irq_instr <= 1'b1;
    @(posedge aclk);
    enable_irq_instr <= 1'b0;
    entry(16'hFFFA, 2'b00, 8'hE2);
    trap_instr <= 1'b1;
    @(posedge aclk);
    trap_instr <= 1'b0;
    entry(16'hFFFC, 2'b11, 8'hC2);
    periph_flag <= 14'h0002;
    restore_cc_data <= 8'hE2;
    return_from_isr_instr <= 1'b1;
    @(posedge aclk);
    return_from_isr_instr <= 1'b0;
    entry(16'hFFF8, 2'b01, 8'hE2);
    disable_irq_instr <= 1'b1;
    @(posedge aclk);
    disable_irq_instr <= 1'b0;
    axr(8'h00);
    chk("cc_di", 32'h28, rd & 32'h28);
    $display("flow done");
  endtask : t_flow

  // Halt lets only wake-capable vectors in first; wait lets any in.
  task automatic t_sleep;
    axw(8'h04, 32'h0202);
    periph_flag <= 14'h0202;
    halt_instr <= 1'b1;
    @(posedge aclk);
    halt_instr <= 1'b0;
    @(negedge aclk);
    chk("wake_halt", 32'h3, {30'h0, cpu_wake, low_power_halt});
    entry(16'hFFF8, 2'b01, 8'hE2);
    entry(16'hFFE8, 2'b11, 8'hCA);
    wait_for_irq_instr <= 1'b1;
    @(posedge aclk);
    wait_for_irq_instr <= 1'b0;
    @(negedge aclk);
    chk("wake_wait", 32'h3, {30'h0, cpu_wake, low_power_wait});
    entry(16'hFFE8, 2'b11, 8'hE2);
    chk("asleep", 32'h0, {30'h0, low_power_halt, low_power_wait});
    $display("sleep done");
  endtask : t_sleep

  // An edge on the second pin of a group is latched once, then cleared.
  task automatic t_ext;
    axw(8'h04, 32'h0008);
    ext_pin <= 8'h08;
    enable_irq_instr <= 1'b1;
    @(posedge aclk);
    enable_irq_instr <= 1'b0;
    entry(16'hFFF4, 2'b01, 8'hE2);
    axr(8'h08);
    chk("ext_pend", 32'h0, rd);
    $display("external done");
  endtask : t_ext

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (3000) @(posedge aclk);
    num_errors++;
    close_out();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, trap_instr, halt_instr} = 4'h0;
    {return_from_isr_instr, enable_irq_instr} = 2'b00;
    {disable_irq_instr, wait_for_irq_instr} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, restore_cc_data, ext_pin} = 32'h0;
    {s_axi_wdata, s_axi_wstrb, periph_flag} = 50'h0;
    s_axi_wstrb = 4'hF;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_flow();
    t_sleep();
    t_ext();
    close_out();
  end
endmodule : nic_top_tb_top
